// File: include/stmr_pkg.sv
`default_nettype none

package stmr_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int NCH   = 2;
    localparam int NEV   = 3;
    localparam int ADR_W = 8;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADR_W-1:0] OFS_CTRL   = 8'h60;
    localparam logic [ADR_W-1:0] OFS_CLR    = 8'h6C;
    localparam logic [ADR_W-1:0] OFS_STAT   = 8'h70;
    localparam logic [ADR_W-1:0] OFS_IEN    = 8'h74;
    localparam logic [ADR_W-1:0] OFS_IDIS   = 8'h78;
    localparam logic [ADR_W-1:0] OFS_IMASK  = 8'h7C;
    localparam logic [ADR_W-1:0] OFS_SETUP0 = 8'h80;
    localparam logic [ADR_W-1:0] OFS_PRE0   = 8'h84;
    localparam logic [ADR_W-1:0] OFS_SETUP1 = 8'h88;
    localparam logic [ADR_W-1:0] OFS_PRE1   = 8'h8C;
    localparam logic [ADR_W-1:0] OFS_CNT0   = 8'h90;
    localparam logic [ADR_W-1:0] OFS_CNT1   = 8'h94;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_SRST    = 0;
    localparam int CTRL_EN0     = 1;
    localparam int CTRL_DIS0    = 2;
    localparam int CTRL_EN1     = 3;
    localparam int CTRL_DIS1    = 4;
    localparam int EV_END       = 0;
    localparam int EV_DRST      = 1;
    localparam int EV_LOAD      = 2;
    localparam int STAT_ON_LSB  = 24;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0]        PRE_RST  = 16'h0000;
    localparam logic [NCH*NEV-1:0] MASK_RST = 6'h00;

    typedef enum logic [3:0] {
        R_NONE, R_CTRL, R_CLR, R_STAT, R_IEN, R_IDIS, R_IMASK,
        R_SETUP0, R_PRE0, R_SETUP1, R_PRE1, R_CNT0, R_CNT1
    } stmr_reg_t;

    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [3:0]        sel;
        logic [ADR_W-1:0]  adr;
        logic [31:0]       dat;
    } stmr_wb_req_t;

    // same bit layout as the clock setup register, bits 18:0
    typedef struct packed {
        logic [10:0] core_divider_value;
        logic [1:0]  spare;
        logic        auto_reload;
        logic        clock_source_select;
        logic [3:0]  div_exp;
    } stmr_setup_t;

    typedef struct packed {
        stmr_setup_t setup;
        logic [15:0] preload;
        logic        channel_on_status;
        logic [15:0] count;
        logic [11:0] core_cnt;
        logic [14:0] pre_cnt;
    } stmr_chan_t;

    typedef struct packed {
        logic                 ack;
        logic [31:0]          dat;
        logic                 irq;
        logic [NCH*NEV-1:0]   mask;
        logic [NCH*NEV-1:0]   status;
        logic                 lf_prev;
        stmr_chan_t [NCH-1:0] ch;
    } stmr_state_t;

endpackage

`default_nettype wire

// File: core/stmr_core.sv
// How it works
// [RULE1] three mask bits per channel: end, divider reset, loaded; 1 passes, 0 blocks
// [RULE2] counter tick is divider clock divided by two to the divide exponent
// [RULE3] source select 0 picks the core divider, 1 the low frequency clock
// [RULE4] auto reload 1 reloads preload value when the counter is at zero
// [RULE5] core divider clock is core clock over two times field plus one
// [RULE6] clock setup writes are taken only while the channel is off
// [RULE7] sixteen bit read/write preload value is the counter start value
// [RULE8] read-only register per channel shows the live counter value
// [RULE9] end-of-count flag sets when the counter counts down to zero
// [RULE10] per-channel status bit reads 1 when on, 0 when off
// [RULE11] without reload the counter decrements per tick and holds at zero
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none

module stmr_core (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // wishbone slave
    input  wire stmr_pkg::stmr_wb_req_t wb_req_i,
    output logic                      wb_ack_o,
    output logic [31:0]               wb_dat_o,
    // low frequency clock, sampled
    input  wire logic                 lf_clk_i,
    // interrupt
    output logic                      irq_o
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic stmr_pkg::stmr_reg_t reg_decode(input logic [stmr_pkg::ADR_W-1:0] a);
        unique case (a)
            stmr_pkg::OFS_CTRL:   reg_decode = stmr_pkg::R_CTRL;
            stmr_pkg::OFS_CLR:    reg_decode = stmr_pkg::R_CLR;
            stmr_pkg::OFS_STAT:   reg_decode = stmr_pkg::R_STAT;
            stmr_pkg::OFS_IEN:    reg_decode = stmr_pkg::R_IEN;
            stmr_pkg::OFS_IDIS:   reg_decode = stmr_pkg::R_IDIS;
            stmr_pkg::OFS_IMASK:  reg_decode = stmr_pkg::R_IMASK;
            stmr_pkg::OFS_SETUP0: reg_decode = stmr_pkg::R_SETUP0;
            stmr_pkg::OFS_PRE0:   reg_decode = stmr_pkg::R_PRE0;
            stmr_pkg::OFS_SETUP1: reg_decode = stmr_pkg::R_SETUP1;
            stmr_pkg::OFS_PRE1:   reg_decode = stmr_pkg::R_PRE1;
            stmr_pkg::OFS_CNT0:   reg_decode = stmr_pkg::R_CNT0;
            stmr_pkg::OFS_CNT1:   reg_decode = stmr_pkg::R_CNT1;
            default:              reg_decode = stmr_pkg::R_NONE;
        endcase
    endfunction

    // byte lane merge of a write into the old word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // last prescale count before a counter tick
    function automatic logic [14:0] pre_last(input logic [3:0] e);
        logic [15:0] p;
        p = (16'h0001 << e) - 16'h0001;
        return p[14:0];
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    stmr_pkg::stmr_state_t st_r;
    stmr_pkg::stmr_state_t st_nxt;
    stmr_pkg::stmr_state_t st_rst;

    stmr_pkg::stmr_reg_t   rsel;
    logic                  req;
    logic                  wr_acc;
    logic [31:0]           wdat;
    logic                  lf_rise;
    logic                  soft_rst;
    logic [stmr_pkg::NCH-1:0] core_tick;
    logic [stmr_pkg::NCH-1:0] src_tick;
    logic [stmr_pkg::NCH-1:0] cnt_tick;
    logic [stmr_pkg::NCH-1:0] en_req;
    logic [stmr_pkg::NCH-1:0] dis_req;
    logic [stmr_pkg::NCH-1:0] start;
    logic [stmr_pkg::NCH-1:0] setup_wr;
    logic [stmr_pkg::NCH*stmr_pkg::NEV-1:0] ev;
    logic [stmr_pkg::NCH*stmr_pkg::NEV-1:0] clr;
    logic [31:0]           rdat;

    always_comb begin
        st_rst         = '0;
        st_rst.mask    = stmr_pkg::MASK_RST;
        st_rst.ch[0].preload = stmr_pkg::PRE_RST;
        st_rst.ch[1].preload = stmr_pkg::PRE_RST;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt    = st_r;
        req       = wb_req_i.cyc && wb_req_i.stb;
        rsel      = reg_decode(wb_req_i.adr);
        // write lands on the edge where the master sees ack
        wr_acc    = req && st_r.ack && wb_req_i.we;
        wdat      = lane_merge(32'h0000_0000, wb_req_i.dat, wb_req_i.sel);
        lf_rise   = lf_clk_i && !st_r.lf_prev;
        soft_rst  = wr_acc && (rsel == stmr_pkg::R_CTRL) && wdat[stmr_pkg::CTRL_SRST];
        ev        = '0;
        clr       = '0;
        core_tick = '0;
        src_tick  = '0;
        cnt_tick  = '0;
        en_req    = '0;
        dis_req   = '0;
        start     = '0;
        setup_wr  = '0;
        st_nxt.lf_prev = lf_clk_i;

        if (wr_acc && rsel == stmr_pkg::R_CTRL) begin
            en_req  = {wdat[stmr_pkg::CTRL_EN1],  wdat[stmr_pkg::CTRL_EN0]};
            dis_req = {wdat[stmr_pkg::CTRL_DIS1], wdat[stmr_pkg::CTRL_DIS0]};
        end
        setup_wr[0] = wr_acc && rsel == stmr_pkg::R_SETUP0;
        setup_wr[1] = wr_acc && rsel == stmr_pkg::R_SETUP1;

        for (int c = 0; c < stmr_pkg::NCH; c++) begin
            // dividers are held cleared while the channel is off
            if (!st_r.ch[c].channel_on_status) begin
                st_nxt.ch[c].core_cnt = '0;
                st_nxt.ch[c].pre_cnt  = '0;
            end else begin
                // [RULE5] core divider period
                core_tick[c] = st_r.ch[c].core_cnt ==
                               {st_r.ch[c].setup.core_divider_value, 1'b1};
                st_nxt.ch[c].core_cnt = core_tick[c] ? 12'h000 :
                                        st_r.ch[c].core_cnt + 12'h001;
                // [RULE3] divider clock source
                src_tick[c] = st_r.ch[c].setup.clock_source_select ? lf_rise : core_tick[c];
                // [RULE2] power of two prescale
                if (src_tick[c]) begin
                    cnt_tick[c] = st_r.ch[c].pre_cnt == pre_last(st_r.ch[c].setup.div_exp);
                    st_nxt.ch[c].pre_cnt = cnt_tick[c] ? 15'h0000 :
                                           st_r.ch[c].pre_cnt + 15'h0001;
                end
                if (cnt_tick[c]) begin
                    if (st_r.ch[c].count == 16'h0000) begin
                        // [RULE4] reload at zero
                        if (st_r.ch[c].setup.auto_reload) begin
                            st_nxt.ch[c].count = st_r.ch[c].preload;
                            ev[c*stmr_pkg::NEV + stmr_pkg::EV_LOAD] = 1'b1;
                        end
                    end else begin
                        // [RULE11] plain decrement, sticks at zero
                        st_nxt.ch[c].count = st_r.ch[c].count - 16'h0001;
                        // [RULE9] end of count event
                        if (st_r.ch[c].count == 16'h0001) begin
                            ev[c*stmr_pkg::NEV + stmr_pkg::EV_END] = 1'b1;
                        end
                    end
                end
            end

            // disable wins over enable when both are written
            if (dis_req[c]) begin
                st_nxt.ch[c].channel_on_status = 1'b0;
                st_nxt.ch[c].core_cnt = '0;
                st_nxt.ch[c].pre_cnt  = '0;
                ev[c*stmr_pkg::NEV + stmr_pkg::EV_DRST] = 1'b1;
            end else if (en_req[c] && !st_r.ch[c].channel_on_status) begin
                // [RULE7] start from the preload value
                start[c] = 1'b1;
                st_nxt.ch[c].channel_on_status = 1'b1;
                st_nxt.ch[c].count    = st_r.ch[c].preload;
                st_nxt.ch[c].core_cnt = '0;
                st_nxt.ch[c].pre_cnt  = '0;
                ev[c*stmr_pkg::NEV + stmr_pkg::EV_LOAD] = 1'b1;
            end

            // [RULE6] setup locked while running
            if (setup_wr[c] && !st_r.ch[c].channel_on_status) begin
                st_nxt.ch[c].setup = stmr_pkg::stmr_setup_t'(lane_merge(
                    32'(st_r.ch[c].setup), wb_req_i.dat, wb_req_i.sel));
            end
        end

        if (wr_acc && rsel == stmr_pkg::R_PRE0) begin
            st_nxt.ch[0].preload = 16'(lane_merge({16'h0000, st_r.ch[0].preload},
                                                  wb_req_i.dat, wb_req_i.sel));
        end
        if (wr_acc && rsel == stmr_pkg::R_PRE1) begin
            st_nxt.ch[1].preload = 16'(lane_merge({16'h0000, st_r.ch[1].preload},
                                                  wb_req_i.dat, wb_req_i.sel));
        end
        if (wr_acc && rsel == stmr_pkg::R_CLR) begin
            clr = wdat[stmr_pkg::NCH*stmr_pkg::NEV-1:0];
        end
        // [RULE1] mask set and clear
        if (wr_acc && rsel == stmr_pkg::R_IEN) begin
            st_nxt.mask = st_r.mask | wdat[stmr_pkg::NCH*stmr_pkg::NEV-1:0];
        end
        if (wr_acc && rsel == stmr_pkg::R_IDIS) begin
            st_nxt.mask = st_r.mask & ~wdat[stmr_pkg::NCH*stmr_pkg::NEV-1:0];
        end
        // a new event beats a clear in the same cycle
        st_nxt.status = (st_r.status & ~clr) | ev;

        // read data
        rdat = 32'h0000_0000;
        unique case (rsel)
            stmr_pkg::R_STAT: begin
                rdat[stmr_pkg::NCH*stmr_pkg::NEV-1:0] = st_r.status;
                // [RULE10] running status bits
                rdat[stmr_pkg::STAT_ON_LSB]     = st_r.ch[0].channel_on_status;
                rdat[stmr_pkg::STAT_ON_LSB + 1] = st_r.ch[1].channel_on_status;
            end
            stmr_pkg::R_IMASK:  rdat[stmr_pkg::NCH*stmr_pkg::NEV-1:0] = st_r.mask;
            stmr_pkg::R_SETUP0: rdat = 32'(st_r.ch[0].setup);
            stmr_pkg::R_SETUP1: rdat = 32'(st_r.ch[1].setup);
            stmr_pkg::R_PRE0:   rdat = {16'h0000, st_r.ch[0].preload};
            stmr_pkg::R_PRE1:   rdat = {16'h0000, st_r.ch[1].preload};
            // [RULE8] live counter values
            stmr_pkg::R_CNT0:   rdat = {16'h0000, st_r.ch[0].count};
            stmr_pkg::R_CNT1:   rdat = {16'h0000, st_r.ch[1].count};
            default:            rdat = 32'h0000_0000;
        endcase

        if (soft_rst) begin
            st_nxt = st_rst;
        end
        // unmapped and write-only offsets answer with zero data
        st_nxt.ack = req && !st_r.ack;
        st_nxt.dat = (req && !st_r.ack && !wb_req_i.we) ? rdat : 32'h0000_0000;
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.dat;
    assign irq_o    = st_r.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic quiet;
    assign quiet = !wr_acc;

    sequence stat_read_s;
        req && !st_r.ack && !wb_req_i.we && rsel == stmr_pkg::R_STAT;
    endsequence

    sequence ack_pulse_s;
        st_r.ack ##1 !st_r.ack;
    endsequence

    ack_single_a: assert property (req && !st_r.ack |=> ack_pulse_s)
        else $error("ack not a single cycle pulse");

    irq_gating_a: assert property (irq_o == |(st_r.status & st_r.mask)) // [RULE1]
        else $error("interrupt not gated by mask");

    setup_locked_a: assert property (setup_wr[1] && st_r.ch[1].channel_on_status // [RULE6]
                                     && !soft_rst |=> $stable(st_r.ch[1].setup))
        else $error("setup changed while channel on");

    enable_load_a: assert property (start[0] && !soft_rst |=> // [RULE7]
                                    st_r.ch[0].channel_on_status
                                    && st_r.ch[0].count == $past(st_r.ch[0].preload)
                                    && st_r.status[stmr_pkg::EV_LOAD])
        else $error("enable did not load preload");

    reload_zero_a: assert property (cnt_tick[1] && quiet && st_r.ch[1].count == 16'h0000 // [RULE4]
                                    && st_r.ch[1].setup.auto_reload
                                    |=> st_r.ch[1].count == $past(st_r.ch[1].preload))
        else $error("no reload at zero");

    hold_zero_a: assert property (cnt_tick[0] && quiet && st_r.ch[0].count == 16'h0000 // [RULE11]
                                  && !st_r.ch[0].setup.auto_reload |=> st_r.ch[0].count == 16'h0000)
        else $error("counter left zero without reload");

    decrement_a: assert property (cnt_tick[1] && quiet && st_r.ch[1].count != 16'h0000 // [RULE11]
                                  |=> st_r.ch[1].count == $past(st_r.ch[1].count) - 16'h0001)
        else $error("counter did not decrement by one");

    end_flag_a: assert property (cnt_tick[0] && quiet && st_r.ch[0].count == 16'h0001 // [RULE9]
                                 |=> st_r.status[stmr_pkg::EV_END] ##1 st_r.status[stmr_pkg::EV_END])
        else $error("end of count flag missing");

    core_div_a: assert property (core_tick[0] && quiet |=> st_r.ch[0].core_cnt == 12'h000 // [RULE5]
                                 ##1 (!core_tick[0] || st_r.ch[0].setup.core_divider_value == 11'h000))
        else $error("core divider period wrong");

    lf_source_a: assert property (src_tick[0] && st_r.ch[0].setup.clock_source_select // [RULE3]
                                  |-> lf_clk_i && !st_r.lf_prev)
        else $error("low frequency source tick without edge");

    prescale_a: assert property (cnt_tick[1] |-> src_tick[1] // [RULE2]
                                 && st_r.ch[1].pre_cnt == pre_last(st_r.ch[1].setup.div_exp))
        else $error("counter tick off the prescale boundary");

    on_readback_a: assert property (stat_read_s |=> // [RULE10]
                                    wb_dat_o[stmr_pkg::STAT_ON_LSB] ==
                                    $past(st_r.ch[0].channel_on_status))
        else $error("status does not show channel on");

endmodule

`default_nettype wire

// File: sim/stmr_tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                   clk_i       = 1'b0;
    logic                   rst_i       = 1'b1;
    stmr_pkg::stmr_wb_req_t wb_req_i    = '0;
    logic                   wb_ack_o;
    logic [31:0]            wb_dat_o;
    logic                   lf_clk_i    = 1'b0;
    logic                   irq_o;
    logic [31:0]            exp_q[$];
    logic [15:0]            lfsr_r      = 16'h0026;
    int                     fails       = 0;
    int                     comparisons = 0;

    always #10 clk_i = ~clk_i;

    stmr_core dut (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wb_req_i (wb_req_i),
        .wb_ack_o (wb_ack_o),
        .wb_dat_o (wb_dat_o),
        .lf_clk_i (lf_clk_i),
        .irq_o    (irq_o)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic complete_run();
        // a note left in the queue means a read never came back
        if (exp_q.size() != 0) begin
            fails++;
            $display("MISMATCH %0t %0d reads never answered", $time, exp_q.size());
        end
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t read data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_irq(input logic exp);
        comparisons++;
        if (irq_o !== exp) begin
            fails++;
            $display("MISMATCH %0t irq %b expected %b", $time, irq_o, exp);
        end
    endtask

    // classic cycle; pre idles extra cycles so reads land on known edges
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                       input int pre);
        repeat (pre + 1) @(posedge clk_i);
        wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
        // no limit here: only the watchdog ends a wait for ack
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        wb_req_i <= '0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        bus(1'b1, adr, dat, 0);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input int pre);
        exp_q.push_back(exp);
        bus(1'b0, adr, 32'h00000000, pre);
    endtask

    task automatic chk_irq(input logic exp);
        repeat (2) @(posedge clk_i);
        cmp_irq(exp);
    endtask

    task automatic lf_pulse();
        @(posedge clk_i);
        lf_clk_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        lf_clk_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    // ------------------------------------------------------------
    // result monitor: every read answer is matched to the oldest note
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_req_i.we === 1'b0) begin
            if (exp_q.size() == 0) begin
                fails++;
                $display("MISMATCH %0t unexpected read answer", $time);
            end else begin
                cmp_rd(wb_dat_o, exp_q.pop_front());
            end
        end
    end

    initial begin
        #(20 * 4000);
        fails++;
        $display("MISMATCH %0t watchdog expired", $time);
        complete_run();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(stmr_pkg::OFS_PRE0, 32'h00000000, 0);
        rd(stmr_pkg::OFS_STAT, 32'h00000000, 0);
        rd(stmr_pkg::OFS_IMASK, 32'h00000000, 0);
        rd(8'hFC, 32'h00000000, 0);
        cmp_irq(1'b0);
        // random preload values, reserved upper half must read back zero
        for (int i = 0; i < 4; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            wr(i[0] ? stmr_pkg::OFS_PRE1 : stmr_pkg::OFS_PRE0, {~lfsr_r, lfsr_r});
            rd(i[0] ? stmr_pkg::OFS_PRE1 : stmr_pkg::OFS_PRE0, {16'h0000, lfsr_r}, 0);
        end
        wr(stmr_pkg::OFS_SETUP0, 32'hFFFFFF3F);
        rd(stmr_pkg::OFS_SETUP0, 32'h0007FF3F, 0);
        // core source, divider 1, exponent 1: one count every 8 clocks
        wr(stmr_pkg::OFS_SETUP0, 32'h00000101);
        wr(stmr_pkg::OFS_PRE0, 32'h00000004);
        wr(stmr_pkg::OFS_CTRL, 32'h00000002);
        rd(stmr_pkg::OFS_CNT0, 32'h00000004, 2);
        rd(stmr_pkg::OFS_CNT0, 32'h00000003, 5);
        rd(stmr_pkg::OFS_CNT0, 32'h00000002, 5);
        rd(stmr_pkg::OFS_CNT0, 32'h00000000, 40);
        rd(stmr_pkg::OFS_STAT, 32'h01000005, 0);
        cmp_irq(1'b0);
        wr(stmr_pkg::OFS_CTRL, 32'h00000004);
        rd(stmr_pkg::OFS_STAT, 32'h00000007, 0);
        wr(stmr_pkg::OFS_CLR, 32'h0000003F);
        // channel 1 with auto reload, one count every 2 clocks
        wr(stmr_pkg::OFS_SETUP1, 32'h00000020);
        wr(stmr_pkg::OFS_PRE1, 32'h00000002);
        wr(stmr_pkg::OFS_CTRL, 32'h00000008);
        wr(stmr_pkg::OFS_CLR, 32'h0000003F);
        rd(stmr_pkg::OFS_STAT, 32'h02000028, 12);
        wr(stmr_pkg::OFS_SETUP1, 32'h0000000F);
        rd(stmr_pkg::OFS_SETUP1, 32'h00000020, 0);
        wr(stmr_pkg::OFS_CTRL, 32'h00000018);
        wr(stmr_pkg::OFS_CLR, 32'h0000003F);
        rd(stmr_pkg::OFS_STAT, 32'h00000000, 0);
        wr(stmr_pkg::OFS_SETUP1, 32'h0000000F);
        rd(stmr_pkg::OFS_SETUP1, 32'h0000000F, 0);
        // exponent 15: the first count is 65536 clocks away, so the start value stands
        wr(stmr_pkg::OFS_CTRL, 32'h00000008);
        rd(stmr_pkg::OFS_CNT1, 32'h00000002, 0);
        wr(stmr_pkg::OFS_CTRL, 32'h00000010);
        // low frequency source: the core clock must not move the count
        wr(stmr_pkg::OFS_SETUP0, 32'h00000010);
        wr(stmr_pkg::OFS_PRE0, 32'h00000003);
        wr(stmr_pkg::OFS_CTRL, 32'h00000002);
        wr(stmr_pkg::OFS_CLR, 32'h0000003F);
        rd(stmr_pkg::OFS_CNT0, 32'h00000003, 10);
        lf_pulse();
        lf_pulse();
        rd(stmr_pkg::OFS_CNT0, 32'h00000001, 30);
        lf_pulse();
        rd(stmr_pkg::OFS_STAT, 32'h01000001, 2);
        chk_irq(1'b0);
        wr(stmr_pkg::OFS_IEN, 32'h00000001);
        chk_irq(1'b1);
        rd(stmr_pkg::OFS_IMASK, 32'h00000001, 0);
        wr(stmr_pkg::OFS_IDIS, 32'h00000001);
        chk_irq(1'b0);
        wr(stmr_pkg::OFS_IEN, 32'h0000003F);
        chk_irq(1'b1);
        wr(stmr_pkg::OFS_CLR, 32'h0000003F);
        chk_irq(1'b0);
        wr(stmr_pkg::OFS_IDIS, 32'h0000002A);
        rd(stmr_pkg::OFS_IMASK, 32'h00000015, 0);
        // soft reset returns every register to zero
        wr(stmr_pkg::OFS_CTRL, 32'h00000001);
        rd(stmr_pkg::OFS_IMASK, 32'h00000000, 0);
        rd(stmr_pkg::OFS_PRE0, 32'h00000000, 0);
        rd(stmr_pkg::OFS_STAT, 32'h00000000, 0);
        @(posedge clk_i);
        complete_run();
    end
endmodule

`default_nettype wire
